/* src/gds_pkg.sv */
// Shared constants and types for the gate drive sequencer.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package gds_pkg;

  // Clock and structure
  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_PH = 3;
  localparam int CNT_W = 12;
  localparam int ADR_W = 8;

  // Input deglitch window, least time so round up
  localparam int DGL_TIME_NS = 50;
  localparam int DGL_CYC = (DGL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DGL_W = 4;

  // Drive, dead and overcurrent deglitch times
  localparam int DRIVE_TIME_NS = 4000;
  localparam int DEAD_TIME_NS = 100;
  localparam int OCP_DEG_TIME_NS = 4000;
  localparam logic [CNT_W-1:0] DRIVE_RST =
    CNT_W'((DRIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DEAD_RST =
    CNT_W'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OCP_DEG_RST =
    CNT_W'((OCP_DEG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_DRIVE = 8'h04;
  localparam logic [ADR_W-1:0] OFS_DEAD = 8'h08;
  localparam logic [ADR_W-1:0] OFS_OCP = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_CFG = 8'h10;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADR_W-1:0] OFS_STATE = 8'h1c;

  // Control fields
  localparam int CTRL_DEAD_EN_BIT = 0;
  localparam int CTRL_LOW_SIDE_REF_SELECT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Configuration fields
  localparam int CFG_DRIVE_CURRENT_SETTING_LSB = 0;
  localparam int CFG_TRIP_LSB = 4;
  localparam int CFG_GAIN_LSB = 8;
  localparam logic [9:0] CFG_RST = 10'h000;

  // Status layout: gate faults low, overcurrent high
  localparam int ST_GF_LSB = 0;
  localparam int ST_OC_LSB = 3;
  localparam int ST_W = 6;
  localparam logic [ST_W-1:0] STATUS_RST = 6'h00;
  localparam logic [ST_W-1:0] MASK_RST = 6'h00;

  // Level decode limits
  localparam logic [2:0] SEVEN_MAX = 3'h6;
  localparam logic [3:0] TRIP_MAX = 4'hf;

  // Commanded side of a half-bridge
  localparam logic [1:0] SIDE_OFF = 2'h0;
  localparam logic [1:0] SIDE_HS = 2'h1;
  localparam logic [1:0] SIDE_LS = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OFF,
    ST_DEAD,
    ST_ON,
    ST_HOLD
  } gds_state_t;

endpackage

/* src/gds_deglitch.sv */
// Input deglitch filter for the PWM command inputs.
// Assumes inputs already synchronous to clk_i.
`timescale 1ns/1ns
module gds_deglitch #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw and filtered levels
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] clean_o
);

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic clean_reg, clean_next;
      logic [gds_pkg::DGL_W-1:0] cnt_reg, cnt_next;

      // Level must stand for the whole window before it passes
      always_comb begin
        clean_next = clean_reg;
        cnt_next = '0;
        if (raw_i[b] != clean_reg) begin
          if (cnt_reg == gds_pkg::DGL_W'(gds_pkg::DGL_CYC - 1)) begin
            clean_next = raw_i[b];
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          clean_reg <= 1'b0;
          cnt_reg <= '0;
        end else begin
          clean_reg <= clean_next;
          cnt_reg <= cnt_next;
        end
      end

      assign clean_o[b] = clean_reg;
    end
  endgenerate

endmodule

/* src/gds_sequencer.sv */
// Three half-bridge gate drive sequencer with a Wishbone register slave.
// Assumes gate-source and drain-source comparators arrive synchronous
// to clk_i; hardware-configured parts strap hw_mode_i high.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns

module gds_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gds_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // PWM commands from the controller
  input wire logic [2:0] high_side_pwm_input_i,
  input wire logic [2:0] low_side_pwm_input_i,
  // Gate-source monitors, high when gate above threshold
  input wire logic [2:0] hs_vgs_on_i,
  input wire logic [2:0] ls_vgs_on_i,
  // Drain-source trip comparators
  input wire logic [2:0] hs_drain_switch_trip_i,
  input wire logic [2:0] ls_switch_sense_pos_trip_i,
  input wire logic [2:0] ls_switch_sense_neg_trip_i,
  // Variant strap and configuration pin levels
  input wire logic hw_mode_i,
  input wire logic [1:0] amplifier_gain_level_i,
  input wire logic [2:0] drive_current_level_i,
  input wire logic [2:0] trip_threshold_pin_level_i,
  // Gate drive controls
  output logic [2:0] hs_gate_on_o,
  output logic [2:0] ls_gate_on_o,
  output logic [2:0] hs_strong_pulldown_o,
  output logic [2:0] ls_strong_pulldown_o,
  output logic [2:0] drive_current_active_o,
  // Analog settings
  output logic [3:0] drive_current_setting_o,
  output logic [3:0] overcurrent_trip_threshold_o,
  output logic [1:0] amplifier_gain_o,
  // Fault indications and interrupt
  output logic [2:0] gate_fault_o,
  output logic [2:0] overcurrent_o,
  output logic irq_o
);

  // Seven-level pin: top code is not a valid level, clamp it
  function automatic logic [2:0] decode_seven(input logic [2:0] lvl);
    decode_seven = (lvl > gds_pkg::SEVEN_MAX) ? gds_pkg::SEVEN_MAX : lvl;
  endfunction

  // Byte-lane merge for a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  logic [2:0] pwm_hs;
  logic [2:0] pwm_ls;

  // Deglitched commands
  gds_deglitch #(
    .W(6)
  ) u_dgl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({low_side_pwm_input_i, high_side_pwm_input_i}),
    .clean_o({pwm_ls, pwm_hs})
  );

  // Register state
  logic [1:0] ctrl_reg, ctrl_next;
  logic [gds_pkg::CNT_W-1:0] drive_reg, drive_next;
  logic [gds_pkg::CNT_W-1:0] dead_reg, dead_next;
  logic [gds_pkg::CNT_W-1:0] ocpdeg_reg, ocpdeg_next;
  logic [9:0] cfg_reg, cfg_next;
  logic [gds_pkg::ST_W-1:0] status_reg, status_next;
  logic [gds_pkg::ST_W-1:0] mask_reg, mask_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic irq_reg, irq_next;
  logic [3:0] idrv_reg, idrv_next;
  logic [3:0] trip_reg, trip_next;
  logic [1:0] gain_reg, gain_next;

  // Per-bridge results gathered for the register file
  logic [2:0] gf_evt;
  logic [2:0] oc_evt;
  logic [2:0] oc_flag;
  logic [2:0] drv_act;

  // Settings actually in force for the variant
  logic [gds_pkg::CNT_W-1:0] drive_len;
  logic [gds_pkg::CNT_W-1:0] dead_len;
  logic [gds_pkg::CNT_W-1:0] ocp_len;
  logic dead_en;
  logic low_side_ref_select_neg;
  logic wr_hit;
  logic rd_req;

  // Zero drive setting would skip the check; treat it as one cycle
  assign drive_len = (drive_reg == '0) ? gds_pkg::CNT_W'(1) : drive_reg;
  assign dead_len = dead_reg;
  assign dead_en = ~hw_mode_i & ctrl_reg[gds_pkg::CTRL_DEAD_EN_BIT];
  assign ocp_len = hw_mode_i ? gds_pkg::OCP_DEG_RST : ocpdeg_reg;
  assign low_side_ref_select_neg = ~hw_mode_i & ctrl_reg[gds_pkg::CTRL_LOW_SIDE_REF_SELECT_BIT];
  assign rd_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  // Writes commit on the edge that sees ack high
  assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

  // Register file next state and read mux
  always_comb begin
    ctrl_next = ctrl_reg;
    drive_next = drive_reg;
    dead_next = dead_reg;
    ocpdeg_next = ocpdeg_reg;
    cfg_next = cfg_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    ack_next = rd_req;
    rdat_next = rdat_reg;
    if (wr_hit) begin
      case (wb_adr_i)
        gds_pkg::OFS_CTRL: ctrl_next = 2'(merge(32'(ctrl_reg), wb_dat_i,
                                                wb_sel_i));
        gds_pkg::OFS_DRIVE: drive_next = 12'(merge(32'(drive_reg), wb_dat_i,
                                                   wb_sel_i));
        gds_pkg::OFS_DEAD: dead_next = 12'(merge(32'(dead_reg), wb_dat_i,
                                                 wb_sel_i));
        gds_pkg::OFS_OCP: ocpdeg_next = 12'(merge(32'(ocpdeg_reg), wb_dat_i,
                                                  wb_sel_i));
        gds_pkg::OFS_CFG: cfg_next = 10'(merge(32'(cfg_reg), wb_dat_i,
                                               wb_sel_i));
        gds_pkg::OFS_MASK: mask_next = 6'(merge(32'(mask_reg), wb_dat_i,
                                                wb_sel_i));
        gds_pkg::OFS_STATUS: begin
          if (wb_sel_i[0]) begin
            status_next = status_reg & ~wb_dat_i[5:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    status_next = status_next | {oc_evt, gf_evt};
    if (rd_req) begin
      case (wb_adr_i)
        gds_pkg::OFS_CTRL: rdat_next = 32'(ctrl_reg);
        gds_pkg::OFS_DRIVE: rdat_next = 32'(drive_reg);
        gds_pkg::OFS_DEAD: rdat_next = 32'(dead_reg);
        gds_pkg::OFS_OCP: rdat_next = 32'(ocpdeg_reg);
        gds_pkg::OFS_CFG: rdat_next = 32'(cfg_reg);
        gds_pkg::OFS_STATUS: rdat_next = 32'(status_reg);
        gds_pkg::OFS_MASK: rdat_next = 32'(mask_reg);
        gds_pkg::OFS_STATE: rdat_next = 32'({oc_flag, drv_act,
                                              ls_gate_on_o, hs_gate_on_o});
        default: rdat_next = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
    irq_next = |(status_next & mask_next);
  end

  // Analog setting selection, pins or registers by variant
  always_comb begin
    if (hw_mode_i) begin
      gain_next = amplifier_gain_level_i;
      idrv_next = {1'b0, decode_seven(drive_current_level_i)};
      trip_next = {1'b0, decode_seven(trip_threshold_pin_level_i)};
    end else begin
      gain_next = cfg_reg[gds_pkg::CFG_GAIN_LSB +: 2];
      idrv_next = cfg_reg[gds_pkg::CFG_DRIVE_CURRENT_SETTING_LSB +: 4];
      trip_next = cfg_reg[gds_pkg::CFG_TRIP_LSB +: 4];
      if (trip_next > gds_pkg::TRIP_MAX) begin
        trip_next = gds_pkg::TRIP_MAX;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= gds_pkg::CTRL_RST;
      drive_reg <= gds_pkg::DRIVE_RST;
      dead_reg <= gds_pkg::DEAD_RST;
      ocpdeg_reg <= gds_pkg::OCP_DEG_RST;
      cfg_reg <= gds_pkg::CFG_RST;
      status_reg <= gds_pkg::STATUS_RST;
      mask_reg <= gds_pkg::MASK_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
      idrv_reg <= 4'h0;
      trip_reg <= 4'h0;
      gain_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      drive_reg <= drive_next;
      dead_reg <= dead_next;
      ocpdeg_reg <= ocpdeg_next;
      cfg_reg <= cfg_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      irq_reg <= irq_next;
      idrv_reg <= idrv_next;
      trip_reg <= trip_next;
      gain_reg <= gain_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign irq_o = irq_reg;
  assign drive_current_setting_o = idrv_reg;
  assign overcurrent_trip_threshold_o = trip_reg;
  assign amplifier_gain_o = gain_reg;
  assign gate_fault_o = status_reg[gds_pkg::ST_GF_LSB +: 3];
  assign overcurrent_o = oc_flag;

  genvar p;
  generate
    for (p = 0; p < gds_pkg::NUM_PH; p++) begin : g_ph
      gds_pkg::gds_state_t state_reg, state_next;
      logic [gds_pkg::CNT_W-1:0] cnt_reg, cnt_next;
      logic [1:0] tgt_reg, tgt_next;
      logic hs_reg, hs_next, ls_reg, ls_next;
      logic hpd_reg, hpd_next, lpd_reg, lpd_next;
      logic drv_reg, drv_next;
      logic gf_reg, gf_next;
      logic [gds_pkg::CNT_W:0] oc_cnt_reg, oc_cnt_next;
      logic ocf_reg, ocf_next;
      logic oce_reg, oce_next;
      logic [1:0] cmd;
      logic start_on;
      logic trip_now;

      // Both commands high means both off
      assign cmd = (pwm_hs[p] & ~pwm_ls[p]) ? gds_pkg::SIDE_HS :
                   (pwm_ls[p] & ~pwm_hs[p]) ? gds_pkg::SIDE_LS :
                   gds_pkg::SIDE_OFF;

      // Sequencing: off, handshake, dead time, drive, hold
      always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        tgt_next = tgt_reg;
        hs_next = hs_reg;
        ls_next = ls_reg;
        hpd_next = hpd_reg;
        lpd_next = lpd_reg;
        drv_next = drv_reg;
        gf_next = 1'b0;
        start_on = 1'b0;
        if (cmd != tgt_reg) begin
          // Abandon any interval, drop the gate now
          tgt_next = cmd;
          hs_next = 1'b0;
          ls_next = 1'b0;
          cnt_next = '0;
          drv_next = hs_reg | ls_reg;
          hpd_next = ls_reg;
          lpd_next = hs_reg;
          state_next = gds_pkg::ST_OFF;
        end else begin
          case (state_reg)
            gds_pkg::ST_OFF: begin
              if (drv_reg) begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == drive_len - 1'b1) begin
                  drv_next = 1'b0;
                  hpd_next = 1'b0;
                  lpd_next = 1'b0;
                  gf_next = hs_vgs_on_i[p] | ls_vgs_on_i[p];
                end
              end
              // Wait as long as the monitors need
              if (!hs_vgs_on_i[p] && !ls_vgs_on_i[p]) begin
                drv_next = 1'b0;
                hpd_next = 1'b0;
                lpd_next = 1'b0;
                cnt_next = '0;
                if (tgt_reg == gds_pkg::SIDE_OFF) begin
                  state_next = gds_pkg::ST_IDLE;
                end else if (dead_en && dead_len != '0) begin
                  state_next = gds_pkg::ST_DEAD;
                end else begin
                  start_on = 1'b1;
                end
              end
            end
            gds_pkg::ST_DEAD: begin
              cnt_next = cnt_reg + 1'b1;
              if (cnt_reg == dead_len - 1'b1) begin
                start_on = 1'b1;
              end
            end
            gds_pkg::ST_ON: begin
              cnt_next = cnt_reg + 1'b1;
              if (cnt_reg == drive_len - 1'b1) begin
                drv_next = 1'b0;
                hpd_next = 1'b0;
                lpd_next = 1'b0;
                gf_next = (tgt_reg == gds_pkg::SIDE_HS) ?
                          ~hs_vgs_on_i[p] : ~ls_vgs_on_i[p];
                state_next = gds_pkg::ST_HOLD;
              end
            end
            gds_pkg::ST_IDLE, gds_pkg::ST_HOLD: begin
            end
            default: state_next = gds_pkg::ST_IDLE;
          endcase
          if (start_on) begin
            // Only one side ever selected by the target code
            hs_next = (tgt_reg == gds_pkg::SIDE_HS);
            ls_next = (tgt_reg == gds_pkg::SIDE_LS);
            hpd_next = (tgt_reg == gds_pkg::SIDE_LS);
            lpd_next = (tgt_reg == gds_pkg::SIDE_HS);
            drv_next = 1'b1;
            cnt_next = '0;
            state_next = gds_pkg::ST_ON;
          end
        end
      end

      // Overcurrent deglitch on the enabled transistor
      always_comb begin
        trip_now = (hs_reg & hs_drain_switch_trip_i[p]) |
                   (ls_reg & (low_side_ref_select_neg ? ls_switch_sense_neg_trip_i[p] :
                              ls_switch_sense_pos_trip_i[p]));
        oc_cnt_next = '0;
        if (trip_now) begin
          oc_cnt_next = (oc_cnt_reg > {1'b0, ocp_len}) ? oc_cnt_reg :
                        oc_cnt_reg + 1'b1;
        end
        ocf_next = trip_now && (oc_cnt_reg >= {1'b0, ocp_len});
        oce_next = ocf_next & ~ocf_reg;
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          state_reg <= gds_pkg::ST_IDLE;
          cnt_reg <= '0;
          tgt_reg <= gds_pkg::SIDE_OFF;
          hs_reg <= 1'b0;
          ls_reg <= 1'b0;
          hpd_reg <= 1'b0;
          lpd_reg <= 1'b0;
          drv_reg <= 1'b0;
          gf_reg <= 1'b0;
          oc_cnt_reg <= '0;
          ocf_reg <= 1'b0;
          oce_reg <= 1'b0;
        end else begin
          state_reg <= state_next;
          cnt_reg <= cnt_next;
          tgt_reg <= tgt_next;
          hs_reg <= hs_next;
          ls_reg <= ls_next;
          hpd_reg <= hpd_next;
          lpd_reg <= lpd_next;
          drv_reg <= drv_next;
          gf_reg <= gf_next;
          oc_cnt_reg <= oc_cnt_next;
          ocf_reg <= ocf_next;
          oce_reg <= oce_next;
        end
      end

      assign hs_gate_on_o[p] = hs_reg;
      assign ls_gate_on_o[p] = ls_reg;
      assign hs_strong_pulldown_o[p] = hpd_reg;
      assign ls_strong_pulldown_o[p] = lpd_reg;
      assign drive_current_active_o[p] = drv_reg;
      assign drv_act[p] = drv_reg;
      assign gf_evt[p] = gf_reg;
      assign oc_evt[p] = oce_reg;
      assign oc_flag[p] = ocf_reg;
    end
  endgenerate

endmodule

/* bench/gds_sequencer_sva.sv */
// Concurrent checks on the gate drive sequencer ports.
// Assumes clk_i and synchronous active-high rst_i of the bound top module.
`timescale 1ns/1ns
module gds_sequencer_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Gate link
  input wire logic [2:0] hs_vgs_on_i,
  input wire logic [2:0] ls_vgs_on_i,
  input wire logic [2:0] hs_drain_switch_trip_i,
  input wire logic [2:0] ls_switch_sense_pos_trip_i,
  input wire logic [2:0] ls_switch_sense_neg_trip_i,
  input wire logic [2:0] hs_gate_on_o,
  input wire logic [2:0] ls_gate_on_o,
  input wire logic [2:0] hs_strong_pulldown_o,
  input wire logic [2:0] ls_strong_pulldown_o,
  input wire logic [2:0] drive_current_active_o,
  input wire logic [2:0] overcurrent_o
);
  logic [11:0] trip_run_reg;
  logic [11:0] trip_run_next;
  logic trip0;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Run of consecutive trip cycles on bridge 0
  assign trip0 = hs_drain_switch_trip_i[0] | ls_switch_sense_pos_trip_i[0] |
    ls_switch_sense_neg_trip_i[0];
  always_comb begin
    trip_run_next = trip0 ? trip_run_reg + 12'h001 : 12'h000;
    if (trip_run_reg == 12'hfff) trip_run_next = trip_run_reg;
  end
  always_ff @(posedge clk_i) begin
    trip_run_reg <= rst_i ? 12'h000 : trip_run_next;
  end

  sequence hs_turns_on;
    $rose(hs_gate_on_o[0]);
  endsequence
  sequence ls_turns_on;
    $rose(ls_gate_on_o[0]);
  endsequence

  no_shoot_a: assert property ((hs_gate_on_o & ls_gate_on_o) == 3'h0)
    else $error("both gates of a bridge on");
  hs_handshake_a: assert property (hs_turns_on |->
    !$past(ls_vgs_on_i[0]))
    else $error("high gate rose with low gate still on");
  ls_handshake_a: assert property (ls_turns_on |->
    !$past(hs_vgs_on_i[0]))
    else $error("low gate rose with high gate still on");
  hs_pulldown_a: assert property (hs_turns_on |->
    ls_strong_pulldown_o[0] && drive_current_active_o[0])
    else $error("no pulldown or drive current at high turn-on");
  ls_pulldown_a: assert property (ls_turns_on |->
    hs_strong_pulldown_o[0] && drive_current_active_o[0])
    else $error("no pulldown or drive current at low turn-on");
  // Limitation: assumes deglitch programmed to at least 8 cycles
  ocp_deglitch_a: assert property ($rose(overcurrent_o[0]) |->
    trip_run_reg >= 12'h008)
    else $error("overcurrent without a long trip");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind gds_sequencer gds_sequencer_sva chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .hs_vgs_on_i(hs_vgs_on_i), .ls_vgs_on_i(ls_vgs_on_i),
  .hs_drain_switch_trip_i(hs_drain_switch_trip_i),
  .ls_switch_sense_pos_trip_i(ls_switch_sense_pos_trip_i),
  .ls_switch_sense_neg_trip_i(ls_switch_sense_neg_trip_i),
  .hs_gate_on_o(hs_gate_on_o), .ls_gate_on_o(ls_gate_on_o),
  .hs_strong_pulldown_o(hs_strong_pulldown_o),
  .ls_strong_pulldown_o(ls_strong_pulldown_o),
  .drive_current_active_o(drive_current_active_o),
  .overcurrent_o(overcurrent_o));

/* bench/gds_gate_model.sv */
// Behavioural model of the six external MOSFET gates.
// Assumes registered gate drive levels on clk_i; the bench sets the delay.
`timescale 1ns/1ns
module gds_gate_model (
  // Clock
  input wire logic clk_i,
  // Gate drive and model controls, [2:0] high side, [5:3] low side
  input wire logic [5:0] gate_on_i,
  input wire logic [5:0] stuck_i,
  input wire logic [7:0] dly_i,
  // Gate-source monitors
  output logic [5:0] vgs_on_o
);
  int cnt [6];
  logic t;

  initial vgs_on_o = 6'h00;
  // Monitor follows drive after dly_i cycles; a stuck gate never charges
  always @(posedge clk_i) begin
    for (int g = 0; g < 6; g++) begin
      t = gate_on_i[g] & ~stuck_i[g];
      if (t !== vgs_on_o[g]) begin
        if (cnt[g] >= int'(dly_i)) begin
          vgs_on_o[g] <= t;
          cnt[g] = 0;
        end else begin
          cnt[g]++;
        end
      end else begin
        cnt[g] = 0;
      end
    end
  end
endmodule

/* bench/gds_sequencer_bench.sv */
// Self-checking bench for the gate drive sequencer.
// Assumes the checker and gate model files are compiled first.
`timescale 1ns/1ns
module gds_sequencer_bench;
  logic clk_i, rst_i, cyc, stb, we, hw, ack, irq;
  logic [7:0] adr, dly;
  logic [3:0] sel, dcs, trip;
  logic [31:0] wdat, rdat, rd, cfg;
  logic [2:0] hin, lin, hvgs, lvgs, htr, lpos, lneg, hg, lg, hpd, lpd;
  logic [2:0] act, gf, oc, dcl, tpl;
  logic [1:0] gl, gain;
  logic [5:0] stuck;
  int failures, n_compared, n, k;
  // Reference register table after reset, last entry unmapped
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20};
  logic [31:0] rv [9] = '{32'h0, 32'h190, 32'ha, 32'h190, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0};

  gds_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .high_side_pwm_input_i(hin), .low_side_pwm_input_i(lin),
    .hs_vgs_on_i(hvgs), .ls_vgs_on_i(lvgs), .hs_drain_switch_trip_i(htr),
    .ls_switch_sense_pos_trip_i(lpos), .ls_switch_sense_neg_trip_i(lneg),
    .hw_mode_i(hw), .amplifier_gain_level_i(gl),
    .drive_current_level_i(dcl), .trip_threshold_pin_level_i(tpl),
    .hs_gate_on_o(hg), .ls_gate_on_o(lg), .hs_strong_pulldown_o(hpd),
    .ls_strong_pulldown_o(lpd), .drive_current_active_o(act),
    .drive_current_setting_o(dcs), .overcurrent_trip_threshold_o(trip),
    .amplifier_gain_o(gain), .gate_fault_o(gf), .overcurrent_o(oc),
    .irq_o(irq));
  gds_gate_model gates (.clk_i(clk_i), .gate_on_i({lg, hg}),
    .stuck_i(stuck), .dly_i(dly), .vgs_on_o({lvgs, hvgs}));

  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Classic single cycle; waits on ack, never on a fixed count
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int j;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    for (j = 0; j < 50 && ack !== 1'b1; j++) @(posedge clk_i);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    if (j == 50) begin
      failures++;
      close_out();
    end
  endtask
  // Bounded wait on a gate, fault or overcurrent bit
  task automatic wait_hi(input int s, input int b);
    int j;
    logic [2:0] v [4];
    for (j = 0; j < 300; j++) begin
      @(posedge clk_i);
      v = '{hg, lg, gf, oc};
      if (v[s][b] === 1'b1) break;
    end
    if (j == 300) begin
      failures++;
      close_out();
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, cyc, stb, we, hw, adr, sel, wdat} = {1'b1, 12'h000, 4'hf, 32'h0};
    {hin, lin, htr, lpos, lneg, stuck, dly} = {15'h0000, 6'h00, 8'h03};
    void'($urandom(22));
    {gl, dcl, tpl} = 8'($urandom);
    step(2);
    rst_i <= 0;
    chk(0, {hg, lg, hpd, lpd, act, gf, oc, irq});
    for (k = 0; k < 9; k++) begin
      wb(0, ra[k], 32'h0);
      chk(rv[k], rd);
    end
    // Short drive and deglitch times, all events unmasked
    wb(1, 8'h04, 32'h1e);
    wb(1, 8'h0c, 32'h14);
    wb(1, 8'h18, 32'h3f);
    cfg = $urandom & 32'h3ff;
    wb(1, 8'h10, cfg);
    step(3);
    chk(cfg[3:0], dcs);
    chk(cfg[7:4], trip);
    chk(cfg[9:8], gain);
    // Hardware variant takes the pin levels, top code clamped
    hw <= 1;
    step(3);
    chk((dcl == 3'h7) ? 3'h6 : dcl, dcs);
    chk((tpl == 3'h7) ? 3'h6 : tpl, trip);
    chk(gl, gain);
    hw <= 0;
    // High-side turn-on, count the pulldown cycles
    hin[0] <= 1;
    wait_hi(0, 0);
    chk(3'h6, {lpd[0], act[0], hpd[0]});
    for (n = 0; n < 500 && lpd[0] === 1'b1; n++) @(posedge clk_i);
    chk(30, n);
    step(3);
    chk(0, gf[0]);
    // Slow handshake into the low side
    dly <= 8'h14;
    hin[0] <= 0;
    lin[0] <= 1;
    wait_hi(1, 0);
    chk(0, {hvgs[0], hg[0]});
    step(40);
    chk(0, gf[0]);
    // Stuck gate raises a fault, masked then cleared
    dly <= 8'h03;
    stuck <= 6'h06;
    hin[1] <= 1;
    wait_hi(0, 1);
    wait_hi(2, 1);
    step(2);
    chk(1, irq);
    wb(1, 8'h18, 32'h0);
    step(2);
    chk(0, irq);
    wb(1, 8'h18, 32'h3f);
    wb(1, 8'h14, 32'h2);
    step(2);
    chk(0, {gf[1], irq});
    hin[1] <= 0;
    // New command cuts the interval short, no fault
    hin[2] <= 1;
    wait_hi(0, 2);
    step(10);
    hin[2] <= 0;
    step(60);
    chk(0, {gf[2], hg[2]});
    // Short pulse is filtered
    hin[2] <= 1;
    step(3);
    hin[2] <= 0;
    for (n = 0; n < 20 && hg[2] !== 1'b1; n++) @(posedge clk_i);
    chk(20, n);
    // Overcurrent on the low side of bridge 0
    lpos[0] <= 1;
    step(10);
    lpos[0] <= 0;
    step(5);
    chk(0, oc[0]);
    lneg[0] <= 1;
    step(40);
    lneg[0] <= 0;
    chk(0, oc[0]);
    htr[0] <= 1;
    step(40);
    htr[0] <= 0;
    chk(0, oc[0]);
    lpos[0] <= 1;
    wait_hi(3, 0);
    step(2);
    chk(1, irq);
    lpos[0] <= 0;
    // Negative sense reference, then dead time into the high side
    wb(1, 8'h00, 32'h3);
    lneg[0] <= 1;
    wait_hi(3, 0);
    chk(1, oc[0]);
    lneg[0] <= 0;
    lin[0] <= 0;
    hin[0] <= 1;
    for (n = 0; n < 100 && lg[0] === 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < 100 && hg[0] !== 1'b1; n++) @(posedge clk_i);
    // Model gate delay plus two sample cycles, then the reset dead time
    chk(32'(gds_pkg::DEAD_RST) + 32'(dly) + 32'h2, n);
    close_out();
  end
endmodule
